// File: cswc_pkg.sv
// constants and types for the card status word coder
package cswc_pkg;

  // ==========================================================
  // status word bytes
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW1_OK_DATA = 8'h9F;
  localparam logic [7:0] SW1_MEM = 8'h92;
  localparam logic [7:0] SW1_REF = 8'h94;
  localparam logic [7:0] SW1_SEC = 8'h98;
  localparam logic [7:0] SW1_BAD_P3 = 8'h67;
  localparam logic [7:0] SW1_BAD_P1P2 = 8'h6B;
  localparam logic [7:0] SW1_BAD_INS = 8'h6D;
  localparam logic [7:0] SW1_BAD_CLA = 8'h6E;
  localparam logic [7:0] SW1_TECH = 8'h6F;
  localparam logic [7:0] SW2_NONE = 8'h00;
  localparam logic [7:0] SW2_MEM_FAULT = 8'h40;
  localparam logic [7:0] SW2_NO_EF = 8'h00;
  localparam logic [7:0] SW2_BAD_ADDR = 8'h02;
  localparam logic [7:0] SW2_NOT_FOUND = 8'h04;
  localparam logic [7:0] SW2_INCONSIST = 8'h08;
  localparam logic [7:0] SW2_NO_PIN = 8'h02;
  localparam logic [7:0] SW2_ACC_FAIL = 8'h04;
  localparam logic [7:0] SW2_PIN_STATE = 8'h08;
  localparam logic [7:0] SW2_INVAL_STATE = 8'h10;
  localparam logic [7:0] SW2_BLOCKED = 8'h40;
  localparam logic [7:0] SW2_MANIP = 8'h60;
  localparam logic [7:0] SW2_NET_AUTH = 8'h70;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // ==========================================================
  // instruction of the response-fetch command
  localparam logic [7:0] INS_FETCH = 8'hC0;

  // ==========================================================
  // file coding
  localparam logic [7:0] STRUCT_TRANSPARENT = 8'h00;
  localparam logic [7:0] STRUCT_LINEAR = 8'h01;
  localparam logic [7:0] STRUCT_CYCLIC = 8'h03;
  localparam logic [7:0] STRUCT_KEY = 8'h11;
  localparam logic [7:0] TYPE_RESERVED = 8'h00;
  localparam logic [7:0] TYPE_MASTER = 8'h01;
  localparam logic [7:0] TYPE_DEDICATED = 8'h02;
  localparam logic [7:0] TYPE_ELEMENTARY = 8'h04;
  localparam int STATUS_VALID_BIT = 0;
  localparam int STATUS_RW_INVAL_BIT = 2;

  // ==========================================================
  // pin code format and access condition nibble count
  localparam int PIN_BYTES = 8;
  localparam int PIN_MIN_DIGITS = 4;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_NINE = 8'h39;
  localparam logic [7:0] PIN_PAD = 8'hFF;
  localparam int ACC_NIBBLES = 6;

  typedef enum logic [4:0] {
    OUT_OK, OUT_OK_DATA, OUT_RETRY_OK, OUT_MEM_FAULT,
    OUT_NO_EF, OUT_BAD_ADDR, OUT_NOT_FOUND, OUT_INCONSIST,
    OUT_NO_PIN, OUT_ACC_FAIL, OUT_PIN_STATE, OUT_INVAL_STATE,
    OUT_BLOCKED, OUT_MANIP, OUT_NET_AUTH, OUT_BAD_P3,
    OUT_BAD_P1P2, OUT_REC_RANGE, OUT_BAD_INS, OUT_BAD_CLA,
    OUT_TECH
  } cswc_outcome_t;

  typedef enum logic [1:0] {
    FS_TRANSPARENT, FS_LINEAR, FS_CYCLIC, FS_KEY
  } cswc_fstruct_t;

  typedef enum logic [1:0] {
    FT_RESERVED, FT_MASTER, FT_DEDICATED, FT_ELEMENTARY
  } cswc_ftype_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_SW1, ST_SW2
  } cswc_state_t;

endpackage

// File: cswc_status_coder.sv
// card status word coder with file, access and pin code coding
`timescale 1ns/1ps
module cswc_status_coder #(
  parameter int LEN_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command completion from the interpreter
  input wire logic cmd_done_i,
  input wire logic [7:0] cmd_ins_i,
  input wire cswc_pkg::cswc_outcome_t outcome_i,
  input wire logic [7:0] detail_i,
  input wire logic [LEN_W-1:0] reset_resp_len_i,
  // status byte transmitter
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic busy_o,
  output logic fetch_ok_o,
  output logic [LEN_W-1:0] fetch_len_o,
  // file description
  input wire cswc_pkg::cswc_fstruct_t fstruct_i,
  input wire cswc_pkg::cswc_ftype_t ftype_i,
  input wire logic file_valid_i,
  input wire logic rw_when_inval_i,
  input wire logic [4*cswc_pkg::ACC_NIBBLES-1:0] acc_nib_i,
  output logic [7:0] fstruct_byte_o,
  output logic [7:0] ftype_byte_o,
  output logic [7:0] fstatus_byte_o,
  output logic [7:0] acc_byte9_o,
  output logic [7:0] acc_byte10_o,
  output logic [7:0] acc_byte11_o,
  // pin code format check
  input wire logic pin_check_i,
  input wire logic pin_unblock_i,
  input wire logic [8*cswc_pkg::PIN_BYTES-1:0] pin_code_i,
  output logic pin_fmt_ok_o,
  output logic pin_fmt_done_o
);

  // ==========================================================
  // state
  typedef struct packed {
    cswc_pkg::cswc_state_t st;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic pend;
    logic [LEN_W-1:0] pend_len;
    logic [7:0] fstruct;
    logic [7:0] ftype;
    logic [7:0] fstatus;
    logic [7:0] acc9;
    logic [7:0] acc10;
    logic [7:0] acc11;
    logic pin_ok;
    logic pin_done;
  } cswc_regs_t;

  cswc_regs_t r_q;
  cswc_regs_t r_d;

  // ==========================================================
  // decoding helpers
  function automatic logic [15:0] cswc_code(
    input cswc_pkg::cswc_outcome_t oc,
    input logic [7:0] det
  );
    logic [15:0] w;
    w = {cswc_pkg::SW1_TECH, cswc_pkg::SW2_NONE};
    case (oc)
      cswc_pkg::OUT_OK:
        w = {cswc_pkg::SW1_OK, cswc_pkg::SW2_NONE};
      cswc_pkg::OUT_OK_DATA:
        w = {cswc_pkg::SW1_OK_DATA, det};
      cswc_pkg::OUT_RETRY_OK:
        w = {cswc_pkg::SW1_MEM, cswc_pkg::NIB_ZERO, det[3:0]};
      cswc_pkg::OUT_MEM_FAULT:
        w = {cswc_pkg::SW1_MEM, cswc_pkg::SW2_MEM_FAULT};
      cswc_pkg::OUT_NO_EF:
        w = {cswc_pkg::SW1_REF, cswc_pkg::SW2_NO_EF};
      cswc_pkg::OUT_BAD_ADDR:
        w = {cswc_pkg::SW1_REF, cswc_pkg::SW2_BAD_ADDR};
      cswc_pkg::OUT_NOT_FOUND:
        w = {cswc_pkg::SW1_REF, cswc_pkg::SW2_NOT_FOUND};
      cswc_pkg::OUT_INCONSIST:
        w = {cswc_pkg::SW1_REF, cswc_pkg::SW2_INCONSIST};
      cswc_pkg::OUT_NO_PIN:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_NO_PIN};
      cswc_pkg::OUT_ACC_FAIL:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_ACC_FAIL};
      cswc_pkg::OUT_PIN_STATE:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_PIN_STATE};
      cswc_pkg::OUT_INVAL_STATE:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_INVAL_STATE};
      cswc_pkg::OUT_BLOCKED:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_BLOCKED};
      cswc_pkg::OUT_MANIP:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_MANIP};
      cswc_pkg::OUT_NET_AUTH:
        w = {cswc_pkg::SW1_SEC, cswc_pkg::SW2_NET_AUTH};
      cswc_pkg::OUT_BAD_P3:
        w = {cswc_pkg::SW1_BAD_P3, det};
      cswc_pkg::OUT_BAD_P1P2:
        w = {cswc_pkg::SW1_BAD_P1P2, cswc_pkg::SW2_NONE};
      cswc_pkg::OUT_REC_RANGE:
        w = {cswc_pkg::SW1_REF, cswc_pkg::SW2_BAD_ADDR};
      cswc_pkg::OUT_BAD_INS:
        w = {cswc_pkg::SW1_BAD_INS, cswc_pkg::SW2_NONE};
      cswc_pkg::OUT_BAD_CLA:
        w = {cswc_pkg::SW1_BAD_CLA, cswc_pkg::SW2_NONE};
      // unknown outcomes fall back to the undiagnosed fault
      default:
        w = {cswc_pkg::SW1_TECH, cswc_pkg::SW2_NONE};
    endcase
    return w;
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    // top bit must be clear, only 0..9 pass
    return (c >= cswc_pkg::CHAR_ZERO) && (c <= cswc_pkg::CHAR_NINE);
  endfunction

  // ==========================================================
  // per-byte pin code classification
  logic [cswc_pkg::PIN_BYTES-1:0] dig_v;
  logic [cswc_pkg::PIN_BYTES-1:0] pad_v;
  logic [cswc_pkg::PIN_BYTES:0] dig_pref;
  logic [cswc_pkg::PIN_BYTES:0] pad_suf;

  assign dig_pref[0] = 1'b1;
  assign pad_suf[cswc_pkg::PIN_BYTES] = 1'b1;

  // byte 1 of the code is the top byte of the vector
  genvar gi;
  generate
    for (gi = 0; gi < cswc_pkg::PIN_BYTES; gi++) begin : g_pin
      localparam int HI = 8 * (cswc_pkg::PIN_BYTES - gi) - 1;
      assign dig_v[gi] = is_digit(pin_code_i[HI -: 8]);
      assign pad_v[gi] = pin_code_i[HI -: 8] == cswc_pkg::PIN_PAD;
      assign dig_pref[gi+1] = dig_pref[gi] & dig_v[gi];
      // padding is judged from the tail, so a digit after FF fails
      assign pad_suf[gi] = pad_suf[gi+1] & pad_v[gi];
    end
  endgenerate

  // digits then padding only, with the split at or after the minimum
  logic pin_shape_ok;
  always_comb begin
    pin_shape_ok = 1'b0;
    for (int k = cswc_pkg::PIN_MIN_DIGITS; k <= cswc_pkg::PIN_BYTES;
         k++) begin
      if (dig_pref[k] && pad_suf[k]) begin
        pin_shape_ok = 1'b1;
      end
    end
  end

  // ==========================================================
  // byte handshake on the status lane
  logic sw_taken;
  // a byte leaves only when offered and taken in the same cycle
  assign sw_taken = r_q.tx_valid && tx_ready_i;

  // ==========================================================
  // next state
  always_comb begin
    logic [15:0] code;
    logic is_fetch;
    r_d = r_q;
    code = cswc_code(outcome_i, detail_i);
    is_fetch = cmd_ins_i == cswc_pkg::INS_FETCH;

    // a fetch that does not directly follow its command is refused
    if (is_fetch && !r_q.pend) begin
      code = {cswc_pkg::SW1_TECH, cswc_pkg::SW2_NONE};
    end

    case (r_q.st)
      cswc_pkg::ST_IDLE: begin
        // a completion while busy is dropped; the interpreter waits
        if (cmd_done_i) begin
          // sw2 is parked so the lane changes only on acceptance
          r_d.sw1 = code[15:8];
          r_d.sw2 = code[7:0];
          r_d.tx_byte = code[15:8];
          r_d.tx_valid = 1'b1;
          r_d.st = cswc_pkg::ST_SW1;
          // any command ends the fetch window; 9F opens a new one
          r_d.pend = code[15:8] == cswc_pkg::SW1_OK_DATA;
          r_d.pend_len = LEN_W'(code[7:0]);
        end
      end
      cswc_pkg::ST_SW1: begin
        if (sw_taken) begin
          r_d.tx_byte = r_q.sw2;
          r_d.st = cswc_pkg::ST_SW2;
        end
      end
      cswc_pkg::ST_SW2: begin
        if (sw_taken) begin
          // back to zero so an idle lane never shows a stale status
          r_d.tx_valid = 1'b0;
          r_d.tx_byte = cswc_pkg::SW2_NONE;
          r_d.st = cswc_pkg::ST_IDLE;
        end
      end
      default: begin
        // unreachable; parks the lane idle
        r_d.st = cswc_pkg::ST_IDLE;
        r_d.tx_valid = 1'b0;
      end
    endcase

    // file structure byte
    case (fstruct_i)
      cswc_pkg::FS_LINEAR: begin
        r_d.fstruct = cswc_pkg::STRUCT_LINEAR;
      end
      cswc_pkg::FS_CYCLIC: begin
        r_d.fstruct = cswc_pkg::STRUCT_CYCLIC;
      end
      cswc_pkg::FS_KEY: begin
        r_d.fstruct = cswc_pkg::STRUCT_KEY;
      end
      default: begin
        r_d.fstruct = cswc_pkg::STRUCT_TRANSPARENT;
      end
    endcase

    // file type byte
    case (ftype_i)
      cswc_pkg::FT_MASTER: begin
        r_d.ftype = cswc_pkg::TYPE_MASTER;
      end
      cswc_pkg::FT_DEDICATED: begin
        r_d.ftype = cswc_pkg::TYPE_DEDICATED;
      end
      cswc_pkg::FT_ELEMENTARY: begin
        r_d.ftype = cswc_pkg::TYPE_ELEMENTARY;
      end
      // the reserved code only ever leaves as zero
      default: begin
        r_d.ftype = cswc_pkg::TYPE_RESERVED;
      end
    endcase

    // file status: unused bits stay zero
    r_d.fstatus = '0;
    r_d.fstatus[cswc_pkg::STATUS_VALID_BIT] = file_valid_i;
    r_d.fstatus[cswc_pkg::STATUS_RW_INVAL_BIT] = rw_when_inval_i;

    // nibble 0 lands in the high half of byte 9, msb first
    r_d.acc9 = acc_nib_i[23:16];
    r_d.acc10 = acc_nib_i[15:8];
    r_d.acc11 = acc_nib_i[7:0];

    // pin code format, one-cycle result
    r_d.pin_done = pin_check_i;
    if (pin_check_i) begin
      r_d.pin_ok = pin_unblock_i ? dig_pref[cswc_pkg::PIN_BYTES]
                                 : pin_shape_ok;
    end

    // ==========================================================
    // length of the implicit select answer, loaded while nothing ran
    if (r_q.st == cswc_pkg::ST_IDLE && r_q.pend && !cmd_done_i
        && r_q.pend_len == '0 && r_q.sw1 == '0) begin
      r_d.pend_len = reset_resp_len_i;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q <= '0;
      r_q.st <= cswc_pkg::ST_IDLE;
      // master file is selected at activation, so a fetch may come first
      r_q.pend <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs, bytes msb first on the wire
  assign tx_valid_o = r_q.tx_valid;
  assign tx_byte_o = r_q.tx_byte;
  // one command in flight: a completion while busy is dropped
  assign busy_o = r_q.tx_valid;
  assign fetch_ok_o = r_q.pend;
  assign fetch_len_o = r_q.pend_len;
  assign fstruct_byte_o = r_q.fstruct;
  assign ftype_byte_o = r_q.ftype;
  assign fstatus_byte_o = r_q.fstatus;
  assign acc_byte9_o = r_q.acc9;
  assign acc_byte10_o = r_q.acc10;
  assign acc_byte11_o = r_q.acc11;
  assign pin_fmt_ok_o = r_q.pin_ok;
  assign pin_fmt_done_o = r_q.pin_done;

endmodule

// File: cswc_status_coder_checker.sv
// assertions for the status word coder
`timescale 1ns/1ps
module cswc_status_coder_checker #(
  parameter int LEN_W = 8
) (
  // clock, reset and command side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_done_i,
  input wire logic [7:0] cmd_ins_i,
  input wire cswc_pkg::cswc_outcome_t outcome_i,
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic busy_o,
  input wire logic fetch_ok_o,
  // coding and pin side
  input wire cswc_pkg::cswc_fstruct_t fstruct_i,
  input wire cswc_pkg::cswc_ftype_t ftype_i,
  input wire logic file_valid_i,
  input wire logic rw_when_inval_i,
  input wire logic [4*cswc_pkg::ACC_NIBBLES-1:0] acc_nib_i,
  input wire logic [7:0] fstruct_byte_o,
  input wire logic [7:0] ftype_byte_o,
  input wire logic [7:0] fstatus_byte_o,
  input wire logic [7:0] acc_byte9_o,
  input wire logic pin_check_i,
  input wire logic pin_fmt_done_o
);
  // ==========================================================
  // accepted bytes of the pair on offer
  logic [1:0] acc_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_valid_o) acc_q <= 2'h0;
    else if (tx_ready_i) acc_q <= acc_q + 2'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // assertions
  a_sw1_start: assert property (
    cmd_done_i && !busy_o |=> tx_valid_o && busy_o)
    else $error("no status byte after command");
  a_sw_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("status byte not held");
  a_pair_end: assert property (
    tx_valid_o && tx_ready_i |=> tx_valid_o == (acc_q == 2'h1))
    else $error("status pair not two bytes");
  a_idle_zero: assert property (
    !tx_valid_o |-> tx_byte_o == 8'h00)
    else $error("idle byte not zero");
  a_ok_code: assert property (
    cmd_done_i && !busy_o && cmd_ins_i != 8'hC0 &&
    outcome_i == cswc_pkg::OUT_OK |=> tx_byte_o == 8'h90)
    else $error("wrong plain success code");
  a_bad_fetch: assert property (
    cmd_done_i && !busy_o && cmd_ins_i == 8'hC0 && !fetch_ok_o
    |=> tx_byte_o == 8'h6F)
    else $error("stray fetch not refused");
  a_struct_key: assert property (
    fstruct_i == cswc_pkg::FS_KEY |=> fstruct_byte_o == 8'h11)
    else $error("wrong key structure code");
  a_type_ef: assert property (
    ftype_i == cswc_pkg::FT_ELEMENTARY |=> ftype_byte_o == 8'h04)
    else $error("wrong elementary type code");
  a_status_rsvd: assert property (
    1'b1 |=> fstatus_byte_o ==
    {5'h00, $past(rw_when_inval_i), 1'b0, $past(file_valid_i)})
    else $error("wrong file status byte");
  a_acc_byte9: assert property (
    1'b1 |=> acc_byte9_o == $past(acc_nib_i[23:16]))
    else $error("wrong access byte");
  a_pin_done: assert property (
    1'b1 |=> pin_fmt_done_o == $past(pin_check_i))
    else $error("pin check done misplaced");
  c_data: cover property (tx_valid_o && tx_byte_o == 8'h9F);
  c_refuse: cover property (cmd_done_i && busy_o);
  c_fetch: cover property (cmd_done_i && cmd_ins_i == 8'hC0);
endmodule
bind cswc_status_coder cswc_status_coder_checker #(.LEN_W(LEN_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cmd_done_i(cmd_done_i),
  .cmd_ins_i(cmd_ins_i), .outcome_i(outcome_i), .tx_ready_i(tx_ready_i),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .busy_o(busy_o),
  .fetch_ok_o(fetch_ok_o), .fstruct_i(fstruct_i), .ftype_i(ftype_i),
  .file_valid_i(file_valid_i), .rw_when_inval_i(rw_when_inval_i),
  .acc_nib_i(acc_nib_i), .fstruct_byte_o(fstruct_byte_o),
  .ftype_byte_o(ftype_byte_o), .fstatus_byte_o(fstatus_byte_o),
  .acc_byte9_o(acc_byte9_o), .pin_check_i(pin_check_i),
  .pin_fmt_done_o(pin_fmt_done_o)
);

// File: cswc_term_model.sv
// terminal model that takes the status words
`timescale 1ns/1ps
module cswc_term_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // status byte link
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o,
  // captured pair
  output logic [15:0] sw_o,
  output logic got_o
);
  logic half_q;
  always @(posedge clk_i) begin
    got_o <= 1'b0;
    tx_ready_o <= slow_i ? ($urandom % 3 == 0) : 1'b1;
    if (rst_i) begin
      half_q <= 1'b0;
      tx_ready_o <= 1'b0;
    end else if (tx_valid_i && tx_ready_o) begin
      // only the status pair is read, reserved data is ignored
      half_q <= !half_q;
      if (half_q) begin
        sw_o[7:0] <= tx_byte_i;
        got_o <= 1'b1;
      end else begin
        sw_o[15:8] <= tx_byte_i;
      end
    end
  end
endmodule

// File: card_status_word_coding_tb.sv
// self-checking bench for the status word coder
`timescale 1ns/1ps
module card_status_word_coding_tb;
  logic clk = 1'b0, rst = 1'b1, done = 1'b0, slow = 1'b0, efok;
  logic fv = 1'b0, rwi = 1'b0, pchk = 1'b0, punb = 1'b0;
  logic [7:0] ins = 8'h00, det = 8'h00;
  logic [23:0] nib = 24'h000000;
  logic [63:0] code = '0;
  cswc_pkg::cswc_outcome_t oc = cswc_pkg::OUT_OK;
  cswc_pkg::cswc_fstruct_t fs = cswc_pkg::FS_TRANSPARENT;
  cswc_pkg::cswc_ftype_t ft = cswc_pkg::FT_RESERVED;
  logic rdy, vld, bsy, fok, pdone, pok, got;
  logic [7:0] txb, flen, sb, tb, stb, a9, a10, a11;
  logic [15:0] sw;
  int n_mismatch = 0, n_compared = 0;
  logic [7:0] fs_tab [4] = '{8'h00, 8'h01, 8'h03, 8'h11};
  logic [7:0] ft_tab [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  logic [15:0] sw_tab [21] = '{16'h9000, 16'h9F00, 16'h9200, 16'h9240,
    16'h9400, 16'h9402, 16'h9404, 16'h9408, 16'h9802, 16'h9804, 16'h9808,
    16'h9810, 16'h9840, 16'h9860, 16'h9870, 16'h6700, 16'h6B00, 16'h9402,
    16'h6D00, 16'h6E00, 16'h6F00};
  always #5 clk = ~clk;
  cswc_status_coder #(.LEN_W(8)) u_cswc_status_coder (
    .clk_i(clk), .rst_i(rst), .cmd_done_i(done), .cmd_ins_i(ins),
    .outcome_i(oc), .detail_i(det), .reset_resp_len_i(8'h1C),
    .tx_ready_i(rdy), .tx_valid_o(vld), .tx_byte_o(txb), .busy_o(bsy),
    .fetch_ok_o(fok), .fetch_len_o(flen), .fstruct_i(fs), .ftype_i(ft),
    .file_valid_i(fv), .rw_when_inval_i(rwi), .acc_nib_i(nib),
    .fstruct_byte_o(sb), .ftype_byte_o(tb), .fstatus_byte_o(stb),
    .acc_byte9_o(a9), .acc_byte10_o(a10), .acc_byte11_o(a11),
    .pin_check_i(pchk), .pin_unblock_i(punb), .pin_code_i(code),
    .pin_fmt_ok_o(pok), .pin_fmt_done_o(pdone));
  cswc_term_model u_cswc_term_model (.clk_i(clk), .rst_i(rst),
    .slow_i(slow), .tx_valid_i(vld), .tx_byte_i(txb), .tx_ready_o(rdy),
    .sw_o(sw), .got_o(got));
  // ==========================================================
  // checking helpers
  task cmp_sw(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp_b(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] exp_sw(cswc_pkg::cswc_outcome_t o,
                                         logic [7:0] d);
    logic [15:0] e;
    e = sw_tab[o];
    if (o == cswc_pkg::OUT_OK_DATA || o == cswc_pkg::OUT_BAD_P3) e[7:0] = d;
    if (o == cswc_pkg::OUT_RETRY_OK) e[3:0] = d[3:0];
    return e;
  endfunction
  function automatic logic pin_ok(logic [63:0] c, logic u);
    int k;
    logic pad, bad;
    logic [7:0] y;
    k = 0;
    pad = 1'b0;
    bad = 1'b0;
    for (int b = 0; b < 8; b++) begin
      y = c[63-8*b -: 8];
      if (!pad && y >= 8'h30 && y <= 8'h39) k++;
      else if (y == 8'hFF) pad = 1'b1;
      else bad = 1'b1;
    end
    return !bad && (u ? k == 8 : k >= 4);
  endfunction
  // ==========================================================
  // one command; dbl repeats the strobe while busy, which is dropped
  task rc(input logic [7:0] i, input cswc_pkg::cswc_outcome_t o,
          input logic [7:0] d, input logic dbl);
    logic [15:0] e;
    int n;
    e = (i == 8'hC0 && !efok) ? 16'h6F00 : exp_sw(o, d);
    efok = e[15:8] == 8'h9F;
    @(posedge clk);
    done <= 1'b1;
    ins <= i;
    oc <= o;
    det <= d;
    @(posedge clk);
    done <= dbl;
    oc <= cswc_pkg::OUT_TECH;
    if (dbl) begin
      @(posedge clk);
      done <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (got !== 1'b1 && n < 60);
    if (got !== 1'b1) begin
      n_mismatch++;
      stop_test;
    end
    cmp_sw(sw, e);
    cmp_b({7'h00, fok}, {7'h00, efok});
    if (efok) cmp_b(flen, d);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] x, d;
    logic [63:0] pc;
    cswc_pkg::cswc_outcome_t o;
    int n;
    void'($urandom(79487));
    efok = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp_b(flen, 8'h1C);
    rc(8'hC0, cswc_pkg::OUT_OK, 8'h00, 1'b0);
    rc(8'hC0, cswc_pkg::OUT_OK, 8'h00, 1'b0);
    rc(8'hA4, cswc_pkg::OUT_OK_DATA, 8'h0F, 1'b0);
    rc(8'hC0, cswc_pkg::OUT_OK_DATA, 8'h05, 1'b0);
    rc(8'hB0, cswc_pkg::OUT_OK, 8'h00, 1'b0);
    rc(8'hC0, cswc_pkg::OUT_OK, 8'h00, 1'b0);
    rc(8'hB2, cswc_pkg::OUT_NO_EF, 8'h00, 1'b1);
    for (int p = 0; p < 4; p++) begin
      slow = p[0];
      for (int i = 0; i < 21; i++) begin
        x = 8'($urandom);
        if (x == 8'hC0) x = 8'hA4;
        d = (p == 3) ? 8'h00 : 8'($urandom);
        o = cswc_pkg::cswc_outcome_t'(i);
        if (i < 7) rc(x, o, d, 1'b0);
        else if (i < 14) rc(x, o, d, 1'b0);
        else rc(x, o, d, 1'b0);
      end
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      fs <= cswc_pkg::cswc_fstruct_t'(i % 4);
      ft <= cswc_pkg::cswc_ftype_t'(i / 4);
      fv <= 1'($urandom);
      rwi <= 1'($urandom);
      nib <= 24'($urandom);
      repeat (2) @(posedge clk);
      #1;
      cmp_b(sb, fs_tab[i % 4]);
      cmp_b(tb, ft_tab[i / 4]);
      cmp_b(stb, {5'h00, rwi, 1'b0, fv});
      cmp_sw({a9, a10}, nib[23:8]);
      cmp_b(a11, nib[7:0]);
    end
    for (int i = 0; i < 45; i++) begin
      n = i % 9;
      // short codes are padded the way a terminal sends them
      for (int b = 0; b < 8; b++) begin
        x = 8'h30 + 8'($urandom % 10);
        pc[63-8*b -: 8] = (b < n) ? x : 8'hFF;
      end
      if (i % 5 == 4) pc[8*($urandom % 8) +: 8] = 8'($urandom);
      @(posedge clk);
      pchk <= 1'b1;
      code <= pc;
      punb <= 1'($urandom);
      @(posedge clk);
      pchk <= 1'b0;
      #1;
      cmp_b({7'h00, pdone}, 8'h01);
      cmp_b({7'h00, pok}, {7'h00, pin_ok(pc, punb)});
    end
    stop_test;
  end
  // hang guard, far beyond the several hundred cycles of the run
  initial begin
    #400000;
    n_mismatch++;
    stop_test;
  end
endmodule
